// file: include/cbp_pkg.sv
// Package: register map, field layout and types of the cell-bus port control registers
package cbp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] FIFO_RESET_CONTROL_OFFSET = 8'h0d;
    localparam logic [7:0] PORT_ADDRESS_OFFSET = 8'h0e;
    localparam int TX_CLEAR_BIT = 7;
    localparam int RX_CLEAR_BIT = 6;
    localparam int OUTPUT_DISABLE_BIT = 5;
    localparam int PORT_ADDR_MSB = 4;
    localparam int PORT_ADDR_W = 5;
    localparam int PORT_INDEX_W = 3;
    localparam logic [1:0] PORT_ADDR_UPPER_RESET = 2'h0;
    localparam logic [7:0] FIFO_RESET_CONTROL_RESET = 8'h00;
    localparam logic OUTPUT_DISABLE_RESET_EARLY = 1'b0;
    localparam logic OUTPUT_DISABLE_RESET_LATER = 1'b1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic output_disable;
        logic [PORT_ADDR_W-1:0] port_bus_address;
    } port_cfg_t;
endpackage

// file: tb/atm_layer_model.sv
// ATM-layer side of the cell bus: polls ports through the address lines
`timescale 1ns/1ps
module atm_layer_model (
    // Clock
    input wire logic ref_clk,
    // Cell-bus address lines
    output logic [cbp_pkg::PORT_ADDR_W-1:0] receive_address_lines,
    output logic [cbp_pkg::PORT_ADDR_W-1:0] transmit_address_lines
);
    // Idle polling address until a port is addressed
    initial begin
        receive_address_lines = 5'h1f;
        transmit_address_lines = 5'h1f;
    end

    // One poll per cycle, changed just after the edge; each port polled has its own address
    task automatic poll(input logic [4:0] rx, input logic [4:0] tx);
        @(posedge ref_clk);
        receive_address_lines <= rx;
        transmit_address_lines <= tx;
    endtask
endmodule // atm_layer_model

// file: tb/cell_bus_port_control_regs_bench.sv
// Self-checking testbench of the cell-bus port control registers
`timescale 1ns/1ps
module cell_bus_port_control_regs_bench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] rx_lines;
    logic [4:0] tx_lines;
    logic rx_sel;
    logic tx_sel;
    logic dis;
    logic [4:0] addr;
    logic tx_clr;
    logic rx_clr;
    logic [7:0] rv;
    logic dis_e;
    logic [4:0] addr_e;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    cell_bus_port_control_regs #(.PORT_INDEX(3'h5), .LATER_SILICON(1'b1)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .receive_address_lines(rx_lines), .transmit_address_lines(tx_lines),
        .receive_selected(rx_sel), .transmit_selected(tx_sel),
        .cell_bus_output_disable(dis), .port_bus_address(addr),
        .transmit_fifo_pointer_clear(tx_clr), .receive_fifo_pointer_clear(rx_clr));

    // Second port on early silicon, only its reset values are looked at
    cell_bus_port_control_regs #(.PORT_INDEX(3'h7), .LATER_SILICON(1'b0)) dut_early (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
        .receive_address_lines(rx_lines), .transmit_address_lines(tx_lines),
        .receive_selected(), .transmit_selected(),
        .cell_bus_output_disable(dis_e), .port_bus_address(addr_e),
        .transmit_fifo_pointer_clear(), .receive_fifo_pointer_clear());

    atm_layer_model model (
        .ref_clk(ref_clk), .receive_address_lines(rx_lines), .transmit_address_lines(tx_lines));

    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // Values after reset, port index 5 on later silicon and port index 7 on early silicon
    task automatic check_defaults();
        chk("address", 8'h05, {3'h0, addr});
        chk("disable", 8'h01, {7'h0, dis});
        chk("early_address", 8'h07, {3'h0, addr_e});
        chk("early_disable", 8'h00, {7'h0, dis_e});
        rd(8'h0e);
        chk("port_address", 8'h25, rv);
        rd(8'h0d);
        chk("fifo_reset", 8'h00, rv);
        model.poll(5'h05, 5'h05);
        #1 chk("rx_sel_disabled", 8'h00, {6'h0, rx_sel, tx_sel});
    endtask

    // Clears pulse one cycle, one write after the other
    task automatic check_clears();
        wr(8'h0d, 8'h80);
        chk("tx_clear", 8'h02, {6'h0, tx_clr, rx_clr});
        wr(8'h0d, 8'h40);
        chk("rx_clear", 8'h01, {6'h0, tx_clr, rx_clr});
        @(posedge ref_clk);
        #1 chk("clears_end", 8'h00, {6'h0, tx_clr, rx_clr});
    endtask

    // Address field, matching on both lines, disable gating
    task automatic check_address();
        // Reserved bits written as zero; changed outside a logic reset, which is not blocked
        wr(8'h0e, 8'h0a);
        chk("address", 8'h0a, {3'h0, addr});
        chk("disable", 8'h00, {7'h0, dis});
        model.poll(5'h0a, 5'h0b);
        #1 chk("rx_match", 8'h02, {6'h0, rx_sel, tx_sel});
        model.poll(5'h0b, 5'h0a);
        #1 chk("tx_match", 8'h01, {6'h0, rx_sel, tx_sel});
        wr(8'h0e, 8'h2a);
        chk("sel_disabled", 8'h00, {6'h0, rx_sel, tx_sel});
        rd(8'h0e);
        chk("port_address", 8'h2a, rv);
    endtask

    // Unmapped place leaves the map alone and reads zero
    task automatic check_unmapped();
        wr(8'h0f, 8'h11);
        rd(8'h0f);
        chk("unmapped", 8'h00, rv);
        rd(8'h0e);
        chk("port_address", 8'h2a, rv);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 check_defaults();
        check_clears();
        check_address();
        check_unmapped();
        test_done();
    end
endmodule // cell_bus_port_control_regs_bench

// file: verilog/cbp_addr_match.sv
// Compares the stored port bus address with the cell-bus address lines
`timescale 1ns/1ps
module cbp_addr_match #(
    parameter int WIDTH = 5
) (
    // Stored address and bus lines
    input wire logic [WIDTH-1:0] port_bus_address,
    input wire logic [WIDTH-1:0] receive_address_lines,
    input wire logic [WIDTH-1:0] transmit_address_lines,
    // Selects
    output logic receive_selected,
    output logic transmit_selected
);
    assign receive_selected = (receive_address_lines == port_bus_address);
    assign transmit_selected = (transmit_address_lines == port_bus_address);
endmodule // cbp_addr_match

// file: verilog/cbp_reset_sync.sv
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module cbp_reset_sync (
    // Clock and raw reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Synchronised reset
    output logic rst_sync_b
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign rst_sync_b = stage2_reg;
endmodule // cbp_reset_sync

// file: verilog/cell_bus_port_control_regs.sv
// Cell-bus port control registers: FIFO pointer clears, output disable, bus address
`timescale 1ns/1ps
// Overview of operation
// R1: Writing one to bit 7 of the FIFO reset control register pulses the transmit FIFO pointer clear.
// R2: Writing one to bit 6 of the FIFO reset control register pulses the receive FIFO pointer clear.
// R3: Software writes zero to reserved bits 5..0 of the first register and 7..6 of the second.
// R4: Bit 5 of the port address register, when one, disables every cell-bus output of the port.
// R5: Bits 4..0 of the port address register hold the five-bit bus address, bit 4 most significant.
// R6: The stored address is compared with the receive and transmit address lines to select the port.
// R7: Software gives each port on the shared cell bus a distinct address.
// R8: After reset the low three address bits equal the port index and the upper two are zero.
// R9: Software changes the disable and address bits only while a logic reset is held; here the register takes writes only outside reset.
// R10: Registers read back the last value written to storage bits, with reserved bits as zero.
module cell_bus_port_control_regs #(
    parameter logic [cbp_pkg::PORT_INDEX_W-1:0] PORT_INDEX = 3'h0,
    parameter bit LATER_SILICON = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [cbp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cbp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cbp_pkg::DATA_W-1:0] reg_rdata,
    // Cell-bus address lines
    input wire logic [cbp_pkg::PORT_ADDR_W-1:0] receive_address_lines,
    input wire logic [cbp_pkg::PORT_ADDR_W-1:0] transmit_address_lines,
    // Port selection and output control
    output logic receive_selected,
    output logic transmit_selected,
    output logic cell_bus_output_disable,
    output logic [cbp_pkg::PORT_ADDR_W-1:0] port_bus_address,
    // FIFO pointer clears
    output logic transmit_fifo_pointer_clear,
    output logic receive_fifo_pointer_clear
);
    localparam logic OUTPUT_DISABLE_RESET = LATER_SILICON ?
        cbp_pkg::OUTPUT_DISABLE_RESET_LATER : cbp_pkg::OUTPUT_DISABLE_RESET_EARLY;
    localparam logic [cbp_pkg::PORT_ADDR_W-1:0] PORT_ADDR_RESET =
        {cbp_pkg::PORT_ADDR_UPPER_RESET, PORT_INDEX};

    logic rst_sync_b;
    cbp_pkg::reg_req_t req;
    cbp_pkg::port_cfg_t cfg_reg;
    cbp_pkg::port_cfg_t cfg_next;
    logic tx_clear_reg;
    logic rx_clear_reg;
    logic [cbp_pkg::DATA_W-1:0] rdata_reg;
    logic [cbp_pkg::DATA_W-1:0] rdata_next;
    logic hit_fifo;
    logic hit_addr;
    logic wr_fifo;
    logic wr_addr;
    logic [cbp_pkg::DATA_W-1:0] addr_reg_view;
    logic rx_sel_raw;
    logic tx_sel_raw;

    cbp_reset_sync u_reset_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rst_sync_b(rst_sync_b)
    );

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Address decode
    assign hit_fifo = (req.addr == cbp_pkg::FIFO_RESET_CONTROL_OFFSET);
    assign hit_addr = (req.addr == cbp_pkg::PORT_ADDRESS_OFFSET);
    assign wr_fifo = req.wr && hit_fifo;
    assign wr_addr = req.wr && hit_addr;

    // Reserved bits are not stored, so they cannot steer anything
    assign cfg_next = wr_addr ?
        '{output_disable: req.wdata[cbp_pkg::OUTPUT_DISABLE_BIT], // R4 R3
          port_bus_address: req.wdata[cbp_pkg::PORT_ADDR_MSB:0]} : cfg_reg; // R5

    // Clear bits are self-clearing, so they read back as zero
    assign addr_reg_view = {2'h0, cfg_reg.output_disable, cfg_reg.port_bus_address}; // R10
    assign rdata_next = !req.rd ? 8'h00 :
        hit_addr ? addr_reg_view :
        hit_fifo ? cbp_pkg::FIFO_RESET_CONTROL_RESET : 8'h00; // R10

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cfg_reg <= '{output_disable: OUTPUT_DISABLE_RESET, // R4
                         port_bus_address: PORT_ADDR_RESET}; // R8
        end else begin
            cfg_reg <= cfg_next; // R5
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_clear_reg <= 1'b0;
            rx_clear_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            tx_clear_reg <= wr_fifo && req.wdata[cbp_pkg::TX_CLEAR_BIT]; // R1
            rx_clear_reg <= wr_fifo && req.wdata[cbp_pkg::RX_CLEAR_BIT]; // R2
            rdata_reg <= rdata_next;
        end
    end

    cbp_addr_match #(
        .WIDTH(cbp_pkg::PORT_ADDR_W)
    ) u_addr_match (
        .port_bus_address(cfg_reg.port_bus_address),
        .receive_address_lines(receive_address_lines),
        .transmit_address_lines(transmit_address_lines),
        .receive_selected(rx_sel_raw),
        .transmit_selected(tx_sel_raw)
    );

    // A disabled port answers no cell-bus cycle
    assign receive_selected = rx_sel_raw && !cfg_reg.output_disable; // R6 R4
    assign transmit_selected = tx_sel_raw && !cfg_reg.output_disable; // R6 R4
    assign cell_bus_output_disable = cfg_reg.output_disable; // R4
    assign port_bus_address = cfg_reg.port_bus_address;
    assign transmit_fifo_pointer_clear = tx_clear_reg;
    assign receive_fifo_pointer_clear = rx_clear_reg;
    assign reg_rdata = rdata_reg;

    // Checks
    AST_TX_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (reg_wr && reg_addr == cbp_pkg::FIFO_RESET_CONTROL_OFFSET && reg_wdata[7])
        |=> transmit_fifo_pointer_clear) // R1
        else $error("transmit clear missing after write");
    AST_TX_CLEAR_END: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        !(reg_wr && reg_addr == cbp_pkg::FIFO_RESET_CONTROL_OFFSET && reg_wdata[7])
        |=> !transmit_fifo_pointer_clear) // R1
        else $error("transmit clear without matching write");
    AST_RX_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        receive_fifo_pointer_clear |-> $past(reg_wr) && $past(reg_wdata[6])
        && $past(reg_addr) == cbp_pkg::FIFO_RESET_CONTROL_OFFSET) // R2
        else $error("receive clear without matching write");
    AST_DISABLE_BLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        cell_bus_output_disable |-> !receive_selected && !transmit_selected) // R4
        else $error("disabled port still selected");
    AST_ADDR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (reg_wr && reg_addr == cbp_pkg::PORT_ADDRESS_OFFSET)
        |=> port_bus_address == $past(reg_wdata[4:0])
        && cell_bus_output_disable == $past(reg_wdata[5])) // R5
        else $error("address register did not take write");
    AST_SELECT: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (!cell_bus_output_disable && receive_address_lines == port_bus_address)
        |-> receive_selected) // R6
        else $error("matching receive address not selected");
    AST_RESET_ADDR: assert property (@(posedge ref_clk)
        $rose(rst_sync_b) |-> port_bus_address == {2'h0, PORT_INDEX}
        && cell_bus_output_disable == OUTPUT_DISABLE_RESET) // R8
        else $error("wrong address after reset");
    AST_READBACK: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (reg_rd && reg_addr == cbp_pkg::PORT_ADDRESS_OFFSET)
        |=> reg_rdata == {2'h0, cell_bus_output_disable, port_bus_address}) // R10
        else $error("address register readback wrong");
    AST_FIFO_READ_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (reg_rd && reg_addr == cbp_pkg::FIFO_RESET_CONTROL_OFFSET) |=> reg_rdata == 8'h00) // R10
        else $error("fifo reset control reads nonzero");
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        !(reg_wr && reg_addr == cbp_pkg::PORT_ADDRESS_OFFSET) |=> $stable(port_bus_address)) // R5
        else $error("address changed without write");

    COV_TX_CLEAR: cover property (@(posedge ref_clk) transmit_fifo_pointer_clear);
    COV_BOTH_CLEAR: cover property (@(posedge ref_clk)
        transmit_fifo_pointer_clear && receive_fifo_pointer_clear);
    COV_RX_SELECT: cover property (@(posedge ref_clk) receive_selected);
    COV_ENABLE: cover property (@(posedge ref_clk) $fell(cell_bus_output_disable));
endmodule // cell_bus_port_control_regs
